// [src/ubs_pkg.sv]
// Purpose: shared constants and types of the serial buffer/status block
// Assumes: 100 MHz clock, 32-bit classic Wishbone register access
// Notes:   all offsets are byte addresses of aligned words

package ubs_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_NS  = 10;
  localparam int unsigned BIT_NS  = 8680;
  // bit time in clock cycles, rounds down
  localparam int unsigned BIT_CYC = BIT_NS / CLK_NS;
  localparam int unsigned CNT_W   = 10;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_TXB  = 8'h00;
  localparam logic [7:0] ADR_RXB  = 8'h04;
  localparam logic [7:0] ADR_TXST = 8'h08;
  localparam logic [7:0] ADR_RXST = 8'h0c;
  localparam logic [7:0] ADR_MODE = 8'h10;

  localparam logic [7:0] TXB_RST  = 8'hff;
  localparam logic [7:0] RXB_RST  = 8'hff;
  localparam logic [7:0] MODE_RST = 8'h00;

  // field positions
  localparam int unsigned TXST_PEND = 1;
  localparam int unsigned TXST_BUSY = 0;
  localparam int unsigned RXST_PE   = 2;
  localparam int unsigned RXST_FE   = 1;
  localparam int unsigned RXST_OVE  = 0;
  localparam int unsigned MODE_UEN  = 7;
  localparam int unsigned MODE_TXE  = 6;
  localparam int unsigned MODE_RXE  = 5;
  localparam int unsigned MODE_LEN8 = 1;
  localparam int unsigned MODE_ERM  = 0;

  // request priority codes
  localparam logic [1:0] PRI_NONE = 2'h0;
  localparam logic [1:0] PRI_ERR  = 2'h1;
  localparam logic [1:0] PRI_RX   = 2'h2;
  localparam logic [1:0] PRI_TX   = 2'h3;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ubs_txst_t;

  typedef struct packed {
    logic       done;
    logic [7:0] data;
    logic       pe;
    logic       fe;
  } ubs_rx_in_t;

  typedef struct packed {
    ubs_txst_t        st;
    logic [CNT_W-1:0] cnt;
    logic [2:0]       nbit;
    logic [7:0]       sh;
    logic             txd;
    logic             last;
  } ubs_tx_t;

  typedef struct packed {
    logic [7:0]  mode;
    logic [7:0]  txb;
    logic [7:0]  rxb;
    logic        pend;
    logic        busy;
    logic        unread;
    logic        pe;
    logic        fe;
    logic        ove;
    logic        ack;
    logic [31:0] dat;
    logic        rq_err;
    logic        rq_rx;
  } ubs_state_t;

endpackage : ubs_pkg

// [src/ubs_tx_shift.sv]
// Purpose: transmit shift register and frame sequencer
// Assumes: one start bit, 7 or 8 data bits lsb first, one stop bit
// Notes:   o_ready also rises in the last stop cycle for gapless frames

`timescale 1ns/1ps

module ubs_tx_shift (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_ce,
  // control
  input  wire logic       i_clear,
  input  wire logic       i_load,
  input  wire logic [7:0] i_data,
  input  wire logic       i_len8,
  // status and line
  output logic            o_ready,
  output logic            o_idle,
  output logic            o_txd,
  output logic            o_last
);

  localparam ubs_pkg::ubs_tx_t TX_RST = '{st: ubs_pkg::TX_IDLE, cnt: '0, nbit: 3'h0,
                                         sh: 8'hff, txd: 1'b1, last: 1'b0};

  ubs_pkg::ubs_tx_t s_ff;
  ubs_pkg::ubs_tx_t nxt_s;
  logic             tick;

  assign tick    = (s_ff.cnt == ubs_pkg::CNT_W'(ubs_pkg::BIT_CYC - 1));
  assign o_idle  = (s_ff.st == ubs_pkg::TX_IDLE);
  assign o_ready = o_idle || ((s_ff.st == ubs_pkg::TX_STOP) && tick); // see RULE20
  assign o_txd   = s_ff.txd;
  assign o_last  = s_ff.last;

  always_comb
  begin
    nxt_s      = s_ff;
    nxt_s.last = 1'b0;
    nxt_s.cnt  = tick ? '0 : s_ff.cnt + 1'b1;
    case (s_ff.st)
      ubs_pkg::TX_IDLE:
      begin
        nxt_s.cnt = '0;
      end
      ubs_pkg::TX_START:
      begin
        if (tick)
        begin
          nxt_s.st  = ubs_pkg::TX_DATA;
          nxt_s.txd = s_ff.sh[0];
          nxt_s.sh  = {1'b1, s_ff.sh[7:1]};
        end
      end
      ubs_pkg::TX_DATA:
      begin
        if (tick && (s_ff.nbit == (i_len8 ? 3'h7 : 3'h6)))
        begin
          nxt_s.st   = ubs_pkg::TX_STOP;
          nxt_s.txd  = 1'b1;
          nxt_s.last = 1'b1; // see RULE19 // see RULE22
        end
        else if (tick)
        begin
          nxt_s.nbit = s_ff.nbit + 3'h1;
          nxt_s.txd  = s_ff.sh[0];
          nxt_s.sh   = {1'b1, s_ff.sh[7:1]};
        end
      end
      default:
      begin
        if (tick)
        begin
          nxt_s.st = ubs_pkg::TX_IDLE;
        end
      end
    endcase
    if (i_load && o_ready)
    begin
      nxt_s.st   = ubs_pkg::TX_START;
      nxt_s.cnt  = '0;
      nxt_s.nbit = 3'h0;
      nxt_s.sh   = i_data;
      nxt_s.txd  = 1'b0;
    end
    if (i_clear)
    begin
      nxt_s = TX_RST;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s_ff <= TX_RST;
    end
    else if (i_ce)
    begin
      s_ff <= nxt_s;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_load;
    i_ce && i_load && o_ready && !i_clear;
  endsequence

  sequence s_start_bit;
    !o_txd && (s_ff.st == ubs_pkg::TX_START);
  endsequence

  a_load_start_bit: assert property (@(posedge i_clk) disable iff (!i_resetn) // see RULE6
    s_load |=> s_start_bit)
    else $error("load did not start a start bit");

  a_last_on_stop: assert property (@(posedge i_clk) disable iff (!i_resetn) // see RULE22
    o_last |-> (o_txd && (s_ff.st == ubs_pkg::TX_STOP) && (s_ff.cnt == '0)))
    else $error("transmit done not at stop bit start");

endmodule : ubs_tx_shift

// [src/ubs_uart.sv]
// Purpose: transmit/receive buffers, transmit status and request lines
// Assumes: receive frames arrive already deserialised on I_RX
// Notes:   registers on classic Wishbone, one-cycle registered ack
//
// The Wishbone slave port and the register addresses were chosen for this implementation.

`timescale 1ns/1ps

// Functional notes
// RULE1 - transmit status read-only, resets to zero
// RULE2 - pending clears on disable or transfer
// RULE3 - buffer write sets pending flag
// RULE4 - software writes only while pending is zero
// RULE5 - busy clears on reset, disable, idle end
// RULE6 - busy sets when byte enters shifter
// RULE7 - software waits done and idle before reinit
// RULE8 - enabled receive copies frame, raises done
// RULE9 - disabled receive keeps buffer, no request
// RULE10 - seven-bit length forces bit seven zero
// RULE11 - overrun discards new character
// RULE12 - receive buffer ones on reset or off
// RULE13 - enabled transmit write starts sending
// RULE14 - disabled transmit ignores buffer write
// RULE15 - transmit buffer byte access, resets ones
// RULE16 - three requests, error highest, transmit lowest
// RULE17 - error request is OR of errors
// RULE18 - mode may route errors to done request
// RULE19 - transmit done after seven/eight bit frame
// RULE20 - next write accepted once byte moved
// RULE21 - mode zero error only, one done only
// RULE22 - transmit done with last stop bit
// RULE23 - transmit buffer read returns last write
module ubs_uart (
  // clock and reset
  input  wire logic                I_CLK,
  input  wire logic                I_RESETN,
  input  wire logic                I_CE,
  // wishbone slave
  input  wire logic                I_WB_CYC,
  input  wire logic                I_WB_STB,
  input  wire logic                I_WB_WE,
  input  wire logic [7:0]          I_WB_ADR,
  input  wire logic [3:0]          I_WB_SEL,
  input  wire logic [31:0]         I_WB_DAT,
  output logic      [31:0]         O_WB_DAT,
  output logic                     O_WB_ACK,
  // serial side
  input  wire ubs_pkg::ubs_rx_in_t I_RX,
  output logic                     O_TXD,
  // requests
  output logic                     O_RX_ERR_REQ,
  output logic                     O_RX_DONE_REQ,
  output logic                     O_TX_DONE_REQ,
  output logic      [1:0]          O_REQ_TOP
);

  localparam ubs_pkg::ubs_state_t ST_RST = '{
    mode:   ubs_pkg::MODE_RST,
    txb:    ubs_pkg::TXB_RST,
    rxb:    ubs_pkg::RXB_RST,
    pend:   1'b0,
    busy:   1'b0,
    unread: 1'b0,
    pe:     1'b0,
    fe:     1'b0,
    ove:    1'b0,
    ack:    1'b0,
    dat:    32'h0000_0000,
    rq_err: 1'b0,
    rq_rx:  1'b0
  };

  // ---------------------------------------------------------------
  // state and decode
  // ---------------------------------------------------------------
  ubs_pkg::ubs_state_t s_ff;
  ubs_pkg::ubs_state_t nxt_s;

  logic uen;
  logic txe;
  logic rxe;
  logic len8;
  logic erm;
  logic tx_on;
  logic rx_on;
  logic req;
  logic wr;
  logic rd;
  logic wr_txb;
  logic load;
  logic tx_ready;
  logic tx_idle;
  logic tx_last;
  logic rx_take;
  logic rx_ovr;
  logic rx_err;

  assign uen   = s_ff.mode[ubs_pkg::MODE_UEN];
  assign txe   = s_ff.mode[ubs_pkg::MODE_TXE];
  assign rxe   = s_ff.mode[ubs_pkg::MODE_RXE];
  assign len8  = s_ff.mode[ubs_pkg::MODE_LEN8];
  assign erm   = s_ff.mode[ubs_pkg::MODE_ERM];
  assign tx_on = uen && txe;
  assign rx_on = uen && rxe;

  // write or read commits at the edge that sees ack high
  assign req    = I_WB_CYC && I_WB_STB;
  assign wr     = req && I_WB_WE && s_ff.ack;
  assign rd     = req && !I_WB_WE && s_ff.ack;
  assign wr_txb = wr && (I_WB_ADR == ubs_pkg::ADR_TXB) && I_WB_SEL[0];

  assign load    = s_ff.pend && tx_ready && tx_on;
  assign rx_take = rx_on && I_RX.done; // see RULE9
  assign rx_ovr  = s_ff.unread;
  assign rx_err  = I_RX.pe || I_RX.fe || rx_ovr;

  // ---------------------------------------------------------------
  // transmit shifter
  // ---------------------------------------------------------------
  ubs_tx_shift u_tx (
    .i_clk    (I_CLK),
    .i_resetn (I_RESETN),
    .i_ce     (I_CE),
    .i_clear  (!tx_on),
    .i_load   (load),
    .i_data   (s_ff.txb),
    .i_len8   (len8),
    .o_ready  (tx_ready),
    .o_idle   (tx_idle),
    .o_txd    (O_TXD),
    .o_last   (tx_last)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_s        = s_ff;
    nxt_s.rq_err = 1'b0;
    nxt_s.rq_rx  = 1'b0;
    nxt_s.ack    = req && !s_ff.ack;
    nxt_s.dat    = 32'h0000_0000;

    // read data, unmapped reads give zero
    if (req && !s_ff.ack && !I_WB_WE)
    begin
      if (I_WB_ADR == ubs_pkg::ADR_TXB)
      begin
        nxt_s.dat[7:0] = s_ff.txb; // see RULE23
      end
      else if (I_WB_ADR == ubs_pkg::ADR_RXB)
      begin
        nxt_s.dat[7:0] = s_ff.rxb;
      end
      else if (I_WB_ADR == ubs_pkg::ADR_TXST)
      begin
        nxt_s.dat[ubs_pkg::TXST_PEND] = s_ff.pend; // see RULE1
        nxt_s.dat[ubs_pkg::TXST_BUSY] = s_ff.busy;
      end
      else if (I_WB_ADR == ubs_pkg::ADR_RXST)
      begin
        nxt_s.dat[ubs_pkg::RXST_PE]  = s_ff.pe;
        nxt_s.dat[ubs_pkg::RXST_FE]  = s_ff.fe;
        nxt_s.dat[ubs_pkg::RXST_OVE] = s_ff.ove;
      end
      else if (I_WB_ADR == ubs_pkg::ADR_MODE)
      begin
        nxt_s.dat[7:0] = s_ff.mode;
      end
    end

    // mode register write
    if (wr && (I_WB_ADR == ubs_pkg::ADR_MODE) && I_WB_SEL[0])
    begin
      nxt_s.mode = I_WB_DAT[7:0];
    end

    // read side effects come before the sets so a set wins
    if (rd && (I_WB_ADR == ubs_pkg::ADR_RXB))
    begin
      nxt_s.unread = 1'b0;
    end
    if (rd && (I_WB_ADR == ubs_pkg::ADR_RXST))
    begin
      nxt_s.pe  = 1'b0;
      nxt_s.fe  = 1'b0;
      nxt_s.ove = 1'b0;
    end

    // transmit buffer and flags
    if (load)
    begin
      nxt_s.pend = 1'b0; // see RULE2
      nxt_s.busy = 1'b1; // see RULE6
    end
    else if (tx_idle && !s_ff.pend)
    begin
      nxt_s.busy = 1'b0; // see RULE5
    end
    if (wr_txb && tx_on) // see RULE14
    begin
      nxt_s.txb  = I_WB_DAT[7:0]; // see RULE15
      nxt_s.pend = 1'b1; // see RULE3 // see RULE13
    end
    if (!tx_on)
    begin
      nxt_s.pend = 1'b0; // see RULE2
      nxt_s.busy = 1'b0; // see RULE5
    end

    // receive transfer and requests
    if (rx_take)
    begin
      // or onto the cleared copy so a same-cycle status read still clears
      nxt_s.pe  = nxt_s.pe || I_RX.pe;
      nxt_s.fe  = nxt_s.fe || I_RX.fe;
      nxt_s.ove = nxt_s.ove || rx_ovr;
      if (!rx_ovr) // see RULE11
      begin
        // overrun leaves the buffer alone
        nxt_s.rxb    = len8 ? I_RX.data : {1'b0, I_RX.data[6:0]}; // see RULE8 // see RULE10
        nxt_s.unread = 1'b1;
      end
      if (rx_err && !erm)
      begin
        nxt_s.rq_err = 1'b1; // see RULE17 // see RULE21
      end
      else
      begin
        nxt_s.rq_rx = 1'b1; // see RULE8 // see RULE18
      end
    end
    if (!rx_on)
    begin
      nxt_s.pe     = 1'b0;
      nxt_s.fe     = 1'b0;
      nxt_s.ove    = 1'b0;
      nxt_s.unread = 1'b0;
    end
    if (!uen)
    begin
      nxt_s.rxb = ubs_pkg::RXB_RST; // see RULE12
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      s_ff <= ST_RST;
    end
    else if (I_CE)
    begin
      s_ff <= nxt_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign O_WB_DAT      = s_ff.dat;
  assign O_WB_ACK      = s_ff.ack;
  assign O_RX_ERR_REQ  = s_ff.rq_err;
  assign O_RX_DONE_REQ = s_ff.rq_rx;
  assign O_TX_DONE_REQ = tx_last; // see RULE19

  // highest pending request this cycle
  always_comb
  begin
    if (s_ff.rq_err)
    begin
      O_REQ_TOP = ubs_pkg::PRI_ERR; // see RULE16
    end
    else if (s_ff.rq_rx)
    begin
      O_REQ_TOP = ubs_pkg::PRI_RX;
    end
    else if (tx_last)
    begin
      O_REQ_TOP = ubs_pkg::PRI_TX;
    end
    else
    begin
      O_REQ_TOP = ubs_pkg::PRI_NONE;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESETN);

  sequence s_txst_read;
    I_CE && req && !s_ff.ack && !I_WB_WE && (I_WB_ADR == ubs_pkg::ADR_TXST);
  endsequence

  sequence s_rx_frame;
    I_CE && rx_take && !rx_ovr;
  endsequence

  a_txst_read_value: assert property ( // see RULE1
    s_txst_read |=> (O_WB_ACK && (O_WB_DAT[31:2] == 30'h0)
                     && (O_WB_DAT[1:0] == {$past(s_ff.pend), $past(s_ff.busy)})))
    else $error("transmit status read wrong");

  a_pend_on_move: assert property ( // see RULE2
    (I_CE && load && !wr_txb) |=> (!s_ff.pend && s_ff.busy))
    else $error("pending not cleared on move");

  a_pend_on_write: assert property ( // see RULE3
    (I_CE && wr_txb && tx_on) |=> (s_ff.pend && (s_ff.txb == $past(I_WB_DAT[7:0]))))
    else $error("pending not set by write");

  a_tx_off_clear: assert property ( // see RULE5
    (I_CE && !tx_on) |=> (!s_ff.pend && !s_ff.busy))
    else $error("transmit flags not cleared");

  a_rx_frame_copy: assert property ( // see RULE8
    s_rx_frame |=> (s_ff.unread && (O_RX_DONE_REQ || O_RX_ERR_REQ)
                    && (s_ff.rxb[6:0] == $past(I_RX.data[6:0]))))
    else $error("receive copy missing");

  a_rx_off_hold: assert property ( // see RULE9
    (I_CE && uen && !rxe && I_RX.done)
    |=> ((s_ff.rxb == $past(s_ff.rxb)) && !O_RX_DONE_REQ && !O_RX_ERR_REQ))
    else $error("disabled receive changed state");

  a_rx_len7_msb: assert property ( // see RULE10
    (I_CE && rx_take && !rx_ovr && !len8) |=> (s_ff.rxb[7] == 1'b0))
    else $error("seven-bit receive msb set");

  a_ovr_discard: assert property ( // see RULE11
    (I_CE && rx_take && rx_ovr) |=> ((s_ff.rxb == $past(s_ff.rxb)) && s_ff.ove))
    else $error("overrun overwrote buffer");

  a_rxb_off_ones: assert property ( // see RULE12
    (I_CE && !uen) |=> (s_ff.rxb == 8'hff))
    else $error("receive buffer not all ones");

  a_txb_ignore: assert property ( // see RULE14
    (I_CE && wr_txb && !tx_on) |=> ((s_ff.txb == $past(s_ff.txb)) && !s_ff.pend))
    else $error("disabled write not ignored");

  a_err_route: assert property ( // see RULE21
    (I_CE && rx_take && rx_err) |=> (O_RX_ERR_REQ == !$past(erm)) && (O_RX_DONE_REQ == $past(erm)))
    else $error("error request routed wrongly");

endmodule : ubs_uart

// [verif/ubs_far_model.sv]
// Purpose: far-side serial device model
// Assumes: one stop bit, data lsb first
// Notes:   receive frames are handed over already deserialised

`timescale 1ns/1ps

module ubs_far_model (
  // clock and line
  input  wire logic           i_clk,
  input  wire logic           i_txd,
  input  wire logic           i_len8,
  // receive frames
  output ubs_pkg::ubs_rx_in_t o_rx
);
  logic [7:0] got [4];
  int         stamp [4];
  int         cnt = 0;
  int         now = 0;
  logic [7:0] b;

  always @(posedge i_clk) now <= now + 1;

  initial o_rx = '0;

  // ------------------------------------------------
  // line decoder, mid-bit sampling
  // ------------------------------------------------
  initial forever
  begin
    @(negedge i_txd);
    stamp[cnt % 4] = now;
    repeat (ubs_pkg::BIT_CYC / 2) @(posedge i_clk);
    b = 8'h00;
    for (int i = 0; i < (i_len8 ? 8 : 7); i++)
    begin
      repeat (ubs_pkg::BIT_CYC) @(posedge i_clk);
      b[i] = i_txd;
    end
    repeat (ubs_pkg::BIT_CYC) @(posedge i_clk);
    got[cnt % 4] = b;
    cnt++;
  end

  // one frame; idle data shows the inverse
  task automatic send(input logic [7:0] d, input logic pe, input logic fe);
    @(posedge i_clk);
    o_rx <= {1'b1, d, pe, fe};
    @(posedge i_clk);
    o_rx <= {1'b0, ~d, ~pe, ~fe};
    repeat (3) @(posedge i_clk);
  endtask : send
endmodule : ubs_far_model

// [verif/tb_ubs_uart.sv]
// Purpose: self-checking bench of the serial buffer/status block
// Assumes: classic Wishbone master, far-side model on the line
// Notes:   one reset row table, then hand-written cases

`timescale 1ns/1ps

module tb_ubs_uart;
  logic                clk;
  logic                rst_n;
  logic                ce;
  logic                cyc;
  logic                stb;
  logic                we;
  logic [7:0]          adr;
  logic [3:0]          sel;
  logic [31:0]         wdat;
  logic [31:0]         rdat;
  logic                ack;
  logic                txd;
  logic                rq_err;
  logic                rq_rx;
  logic                rq_tx;
  logic [1:0]          rq_top;
  ubs_pkg::ubs_rx_in_t rx;
  logic [7:0]          q;
  logic [7:0]          r_adr [6];
  logic [7:0]          r_exp [6];
  int                  n_errors = 0;
  int                  n_checks = 0;
  int                  n_tx = 0;
  int                  n_rx = 0;
  int                  n_er = 0;
  int                  cyc_n = 0;
  int                  s_rx;
  int                  s_er;
  int                  s_tx;

  ubs_uart u_ubs_uart (
    .I_CLK(clk), .I_RESETN(rst_n), .I_CE(ce),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
    .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_RX(rx), .O_TXD(txd), .O_RX_ERR_REQ(rq_err), .O_RX_DONE_REQ(rq_rx),
    .O_TX_DONE_REQ(rq_tx), .O_REQ_TOP(rq_top)
  );

  ubs_far_model u_ubs_far_model (
    .i_clk(clk), .i_txd(txd), .i_len8(1'b1), .o_rx(rx)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s);
    int k;
    k = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= {24'h0, d};
    do
    begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    // data taken at the edge that sees ack, request released right after it
    q = rdat[7:0];
    if (ack !== 1'b1)
      chk("wb ack", 8'h01, 8'h00);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00, 4'h1);
    chk(nm, e, q);
  endtask : rd

  task automatic wait_idle;
    for (int i = 0; i < 40; i++)
    begin
      repeat (50) @(posedge clk);
      wb(1'b0, ubs_pkg::ADR_TXST, 8'h00, 4'h1);
      if (q === 8'h00)
        break;
    end
  endtask : wait_idle

  task automatic snap;
    s_rx = n_rx;
    s_er = n_er;
    s_tx = n_tx;
  endtask : snap

  // ------------------------------------------------
  // request monitor and timeout
  // ------------------------------------------------
  always @(negedge clk)
    if (rst_n === 1'b1)
    begin
      if (rq_tx === 1'b1)
      begin
        n_tx++;
        chk("stop level", 8'h01, {7'h0, txd});
        chk("top tx", 8'h03, {6'h0, rq_top});
      end
      if (rq_err === 1'b1)
      begin
        n_er++;
        chk("top err", 8'h01, {6'h0, rq_top});
      end
      else if (rq_rx === 1'b1)
      begin
        n_rx++;
        chk("top rx", 8'h02, {6'h0, rq_top});
      end
    end

  always @(posedge clk)
  begin
    cyc_n++;
    if (cyc_n == 80000)
    begin
      n_errors++;
      finish_test();
    end
  end

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    ce    = 1'b1;
    cyc   = 1'b0;
    stb   = 1'b0;
    we    = 1'b0;
    adr   = 8'h00;
    sel   = 4'h0;
    wdat  = 32'h0;
    r_adr = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20};
    r_exp = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (4) @(negedge clk);
    chk("reset line", 8'h01, {7'h0, txd});
    chk("reset ack", 8'h00, {7'h0, ack});
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++)
      rd("reset value", r_adr[i], r_exp[i]);
    $display("test reset done");

    wb(1'b1, ubs_pkg::ADR_TXB, 8'h55, 4'h1);
    rd("txb off", ubs_pkg::ADR_TXB, 8'hff);
    wb(1'b1, ubs_pkg::ADR_TXST, 8'hff, 4'h1);
    rd("txst ro", ubs_pkg::ADR_TXST, 8'h00);
    wb(1'b1, ubs_pkg::ADR_MODE, 8'he2, 4'h0);
    rd("mode sel", ubs_pkg::ADR_MODE, 8'h00);
    wb(1'b1, ubs_pkg::ADR_MODE, 8'he2, 4'h1);
    $display("test refused done");

    snap();
    wb(1'b1, ubs_pkg::ADR_TXB, 8'ha5, 4'h1);
    rd("txst moved", ubs_pkg::ADR_TXST, 8'h01);
    wb(1'b1, ubs_pkg::ADR_TXB, 8'h3c, 4'h1);
    rd("txst pend", ubs_pkg::ADR_TXST, 8'h03);
    rd("txb read", ubs_pkg::ADR_TXB, 8'h3c);
    for (int k = 0; k < 30000 && u_ubs_far_model.cnt < 2; k++)
      @(posedge clk);
    chk("byte 0", 8'ha5, u_ubs_far_model.got[0]);
    chk("byte 1", 8'h3c, u_ubs_far_model.got[1]);
    chk("no gap", 8'h01, {7'h0, (u_ubs_far_model.stamp[1] - u_ubs_far_model.stamp[0])
        == 10 * ubs_pkg::BIT_CYC});
    wait_idle();
    chk("txst idle", 8'h00, q);
    chk("tx reqs", 8'h02, 8'(n_tx - s_tx));
    $display("test transmit done");

    snap();
    u_ubs_far_model.send(8'h81, 1'b0, 1'b0);
    rd("rxb 8bit", ubs_pkg::ADR_RXB, 8'h81);
    chk("rx req", 8'h01, 8'(n_rx - s_rx));
    wb(1'b1, ubs_pkg::ADR_MODE, 8'he0, 4'h1);
    u_ubs_far_model.send(8'hff, 1'b0, 1'b0);
    rd("rxb 7bit", ubs_pkg::ADR_RXB, 8'h7f);
    u_ubs_far_model.send(8'h11, 1'b0, 1'b0);
    u_ubs_far_model.send(8'h22, 1'b0, 1'b0);
    rd("rxb overrun", ubs_pkg::ADR_RXB, 8'h11);
    chk("err req", 8'h01, 8'(n_er - s_er));
    rd("overrun flag", ubs_pkg::ADR_RXST, 8'h01);
    snap();
    wb(1'b1, ubs_pkg::ADR_MODE, 8'he3, 4'h1);
    u_ubs_far_model.send(8'h44, 1'b1, 1'b0);
    chk("mode1 err", 8'h00, 8'(n_er - s_er));
    chk("mode1 rx", 8'h01, 8'(n_rx - s_rx));
    rd("rxb parity", ubs_pkg::ADR_RXB, 8'h44);
    wb(1'b1, ubs_pkg::ADR_MODE, 8'hc3, 4'h1);
    u_ubs_far_model.send(8'h99, 1'b0, 1'b1);
    rd("rxb kept", ubs_pkg::ADR_RXB, 8'h44);
    chk("rx off req", 8'h01, 8'(n_rx - s_rx + n_er - s_er));
    wb(1'b1, ubs_pkg::ADR_MODE, 8'h00, 4'h1);
    rd("rxb chan off", ubs_pkg::ADR_RXB, 8'hff);
    $display("test receive done");

    snap();
    wb(1'b1, ubs_pkg::ADR_MODE, 8'he2, 4'h1);
    wb(1'b1, ubs_pkg::ADR_TXB, 8'h0f, 4'h1);
    repeat (2000) @(posedge clk);
    wb(1'b1, ubs_pkg::ADR_MODE, 8'ha2, 4'h1);
    rd("txst abort", ubs_pkg::ADR_TXST, 8'h00);
    chk("line abort", 8'h01, {7'h0, txd});
    repeat (8000) @(posedge clk);
    chk("abort req", 8'h00, 8'(n_tx - s_tx));
    $display("test abort done");

    snap();
    wb(1'b1, ubs_pkg::ADR_MODE, 8'he2, 4'h1);
    wb(1'b1, ubs_pkg::ADR_TXB, 8'h0f, 4'h1);
    repeat (2000) @(posedge clk);
    // frozen longer than a whole frame: the frame must still be running
    ce <= 1'b0;
    repeat (10000) @(posedge clk);
    ce <= 1'b1;
    rd("ce frozen", ubs_pkg::ADR_TXST, 8'h01);
    chk("ce req", 8'h00, 8'(n_tx - s_tx));
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk("reset mid line", 8'h01, {7'h0, txd});
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++)
      rd("reset mid value", r_adr[i], r_exp[i]);
    $display("test freeze and reset done");
    finish_test();
  end
endmodule : tb_ubs_uart
